// *** dv/mscp_host_model.sv ***
`timescale 1ns/1ps
module mscp_host_model (
    // clock
    input  wire logic  sys_clk,
    // pacing
    input  wire logic  slow,
    // link
    output logic       tx_ready,
    output logic [7:0] rx_data,
    output logic       rx_valid
);
    logic [1:0] pace_q = 2'h0;
    initial begin
        tx_ready = 1'b0;
        rx_data = 8'h5A;
        rx_valid = 1'b0;
    end
    // slow host takes one byte in four
    always @(posedge sys_clk) begin
        pace_q <= #1 pace_q + 2'h1;
        tx_ready <= #1 !slow || pace_q == 2'h3;
    end
    function real to_mm(input logic [15:0] dw);
        return dw * 40.824 / 65519.0 - 0.4204872;
    endfunction : to_mm
    task send_byte(input logic [7:0] b);
        @(posedge sys_clk);
        #1;
        rx_data = b;
        rx_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        rx_valid = 1'b0;
        rx_data = ~b;
    endtask : send_byte
    task send_word(input logic [31:0] w);
        for (int i = 0; i < 4; i++) send_byte(w[8*i +: 8]);
    endtask : send_word
    task send_cmd(input logic [15:0] code, input logic [15:0] len);
        send_byte(8'h2B);
        send_byte(8'h0D);
        send_word(32'h0D2B2B2B);
        send_word(32'h7E11C0DE);
        send_word({len, 2'b00, code[13:0]});
        for (int i = 0; i < len; i++) send_word({16'h0, i[15:0]});
    endtask : send_cmd
endmodule : mscp_host_model

// *** dv/mscp_port_monitor.sv ***
`timescale 1ns/1ps
module mscp_port_monitor
    import mscp_pkg::*;
(
    // clock and reset
    input wire logic            sys_clk,
    input wire logic            rst,
    // measurement and link
    input wire logic            meas_valid,
    input wire logic            meas_ready,
    input wire logic [7:0]      tx_data,
    input wire logic            tx_valid,
    input wire logic            tx_ready,
    // command side
    input mscp_pkg::mscp_cmd_t  cmd,
    input mscp_pkg::mscp_op_t   cmd_op,
    input wire logic            cmd_strobe,
    input wire logic            cmd_done,
    // status
    input wire logic            output_enabled,
    input wire logic            threshold_adaptive,
    input wire logic            reset_request
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed early");
    property p_strobe_pulse;
        cmd_strobe |=> !cmd_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
    property p_stop;
        cmd_done && cmd_op == MSCP_OP_STOP |-> ##[1:100] !output_enabled;
    endproperty
    a_stop: assert property (p_stop) else $error("output not stopped");
    property p_start;
        cmd_done && cmd_op == MSCP_OP_START |-> ##[1:100] output_enabled;
    endproperty
    a_start: assert property (p_start) else $error("output not started");
    property p_thresh;
        cmd_done && cmd_op inside {MSCP_OP_TH_ADAPT, MSCP_OP_TH_FIXED}
            |-> ##[1:100] threshold_adaptive == (cmd_op == MSCP_OP_TH_ADAPT);
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold mode wrong");
    property p_refuse;
        !output_enabled |-> !meas_ready;
    endproperty
    a_refuse: assert property (p_refuse) else $error("measurement taken while stopped");
    property p_dec_read;
        cmd.code == 16'h2025 |-> cmd_op == MSCP_OP_RD_OPT;
    endproperty
    a_dec_read: assert property (p_dec_read) else $error("read decode wrong");
    property p_dec_save;
        cmd.code == 16'h202A |-> cmd_op == MSCP_OP_SV_PRG;
    endproperty
    a_dec_save: assert property (p_dec_save) else $error("save decode wrong");
    property p_reset_req;
        cmd_done && cmd_op == MSCP_OP_RESET |-> ##[1:100] reset_request;
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("no reset request");
    c_meas: cover property (meas_valid && meas_ready);
    c_cmd: cover property (cmd_strobe);
    c_reset: cover property (reset_request);
endmodule : mscp_port_monitor

// *** dv/test_measurement_serial_command_port.sv ***
`timescale 1ns/1ps
module test_measurement_serial_command_port;
    import mscp_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        meas_valid = 1'b0;
    logic        cmd_done = 1'b0;
    logic        cmd_fail = 1'b0;
    logic        slow = 1'b0;
    logic        meas_ready, rx_valid, tx_valid, tx_ready, cmd_strobe, fl;
    logic        output_enabled, threshold_adaptive, reset_request;
    logic [7:0]  rx_data, tx_data;
    logic [8:0]  e;
    logic [31:0] rng = 32'h1931;
    logic [31:0] r;
    logic [8:0]  exp_q[$];
    int          mismatches = 0;
    int          check_count = 0;
    mscp_meas_t  meas = '0;
    mscp_cmd_t   cmd;
    mscp_op_t    cmd_op;
    logic [31:0] cw[19] = '{32'h2021, 32'h2001, 32'h2011, 32'h2022, 32'h12023, 32'h22024,
        32'h2025, 32'h2026, 32'hB2027, 32'hF2028, 32'h2029, 32'h202A, 32'h202B, 32'h202C,
        32'h202D, 32'h202E, 32'h2033, 32'h2034, 32'h2099};
    mscp_op_t    ops[19] = '{MSCP_OP_STOP, MSCP_OP_RESET, MSCP_OP_DEVICE_INFORMATION_CMD, MSCP_OP_START,
        MSCP_OP_PROG, MSCP_OP_EDGE, MSCP_OP_RD_OPT, MSCP_OP_RD_PRG, MSCP_OP_WR_OPT,
        MSCP_OP_WR_PRG, MSCP_OP_SV_OPT, MSCP_OP_SV_PRG, MSCP_OP_TRG_RST, MSCP_OP_TRG_GO,
        MSCP_OP_TH_ADAPT, MSCP_OP_TH_FIXED, MSCP_OP_EXT_RD, MSCP_OP_EXT_CLR, MSCP_OP_NONE};

    mscp_port mscp_port_inst (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .meas(meas),
        .meas_valid(meas_valid), .meas_ready(meas_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .cmd(cmd), .cmd_op(cmd_op), .cmd_strobe(cmd_strobe), .cmd_done(cmd_done),
        .cmd_fail(cmd_fail), .output_enabled(output_enabled),
        .threshold_adaptive(threshold_adaptive), .reset_request(reset_request));
    mscp_host_model host_inst (.sys_clk(sys_clk), .slow(slow), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid));

    always #5 sys_clk = ~sys_clk;

    function logic [31:0] xr();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xr
    task close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD %0t value %h expected %h", $time, seen, want);
        end
    endtask : check
    task step();
        @(posedge sys_clk);
        #1;
    endtask : step
    task timed_out();
        mismatches++;
        $display("BAD %0t wait ran out", $time);
        close_out();
    endtask : timed_out
    task drain();
        for (int n = 0; exp_q.size() > 0; n++) begin
            if (n > 800) timed_out();
            step();
        end
    endtask : drain
    task send_meas(input logic [15:0] raw, input logic [1:0] seg, input logic er,
                   input logic [3:0] code);
        logic [15:0] v;
        v = er ? {12'hFFF, code} : (raw > 16'hFFEF ? 16'hFFEF : raw);
        exp_q.push_back({3'b100, v[5:0]});
        exp_q.push_back({3'b101, v[11:6]});
        exp_q.push_back({3'b110, seg, v[15:12]});
        meas = '{raw, seg, er, code};
        meas_valid = 1'b1;
        for (int n = 0; meas_ready !== 1'b1; n++) begin
            if (n > 800) timed_out();
            step();
        end
        step();
        meas_valid = 1'b0;
        step();
    endtask : send_meas

    // tx bytes are steady at the falling edge before the taking edge
    always @(negedge sys_clk) begin
        if (rst === 1'b0 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("BAD %0t unexpected byte %h", $time, tx_data);
            end else begin
                e = exp_q.pop_front();
                if (e[8]) check(tx_data, e[7:0]);
            end
        end
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check(output_enabled, 1'b1);
        check(threshold_adaptive, 1'b0);
        check(tx_valid, 1'b0);
        for (int i = 0; i < 10; i++) begin
            r = xr();
            slow = r[31];
            send_meas(i == 0 ? 16'hFFF0 : (i == 1 ? 16'hFFEF : r[15:0]), r[17:16],
                i > 1 && r[19:18] == 2'b00, (r[3:0] == 4'hC || r[3:0] == 4'h0) ? 4'h1 : r[3:0]);
        end
        drain();
        check($rtoi(host_inst.to_mm(16'hFFEF) * 1.0E4), 32'd404035);
        for (int i = 0; i < 19; i++) begin
            fl = i == 18 || ops[i] inside {MSCP_OP_PROG, MSCP_OP_WR_OPT, MSCP_OP_TRG_RST,
                MSCP_OP_EXT_RD};
            slow = i[0];
            host_inst.send_cmd(cw[i][15:0], cw[i][31:16]);
            exp_q.push_back({1'b1, cw[i][7:0]});
            exp_q.push_back({1'b1, cw[i][15:8] | 8'h80 | {1'b0, fl, 6'h0}});
            exp_q.push_back(9'h103);
            exp_q.push_back(9'h100);
            repeat (4) exp_q.push_back({!fl, 8'h00});
            if (i < 18) begin
                for (int n = 0; cmd_strobe !== 1'b1; n++) begin
                    if (n > 50) timed_out();
                    step();
                end
                check(cmd.code, cw[i][15:0]);
                check(cmd.length, cw[i][31:16]);
                check(cmd_op, ops[i]);
                cmd_done = 1'b1;
                cmd_fail = fl;
                step();
                cmd_done = 1'b0;
                cmd_fail = xr() > 32'h7FFFFFFF;
            end
            drain();
            if (ops[i] == MSCP_OP_RESET) check(output_enabled, 1'b1);
            if (ops[i] == MSCP_OP_START) check(output_enabled, 1'b1);
            if (ops[i] == MSCP_OP_TH_ADAPT) check(threshold_adaptive, 1'b1);
            if (ops[i] == MSCP_OP_TH_FIXED) check(threshold_adaptive, 1'b0);
            if (ops[i] == MSCP_OP_STOP) begin
                check(output_enabled, 1'b0);
                meas = 23'(xr());
                meas_valid = 1'b1;
                repeat (6) step();
                check(meas_ready, 1'b0);
                meas_valid = 1'b0;
            end
        end
        send_meas(16'h1234, 2'b11, 1'b0, 4'h0);
        drain();
        close_out();
    end
endmodule : test_measurement_serial_command_port

bind mscp_port mscp_port_monitor mscp_port_monitor_inst (.sys_clk(sys_clk), .rst(rst),
    .meas_valid(meas_valid), .meas_ready(meas_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .cmd(cmd), .cmd_op(cmd_op),
    .cmd_strobe(cmd_strobe), .cmd_done(cmd_done), .output_enabled(output_enabled),
    .threshold_adaptive(threshold_adaptive), .reset_request(reset_request));

// *** logic/mscp_decode.sv ***
`timescale 1ns/1ps
`include "mscp_defs.svh"
module mscp_decode (
    // command word
    input  wire logic [15:0]  code,
    // decoded operation
    output mscp_pkg::mscp_op_t op
);
    import mscp_pkg::*;
    always_comb begin
        case (code)
            `MSCP_C_RESET:    op = MSCP_OP_RESET;
            `MSCP_C_DEVICE_INFORMATION_CMD:     op = MSCP_OP_DEVICE_INFORMATION_CMD;
            `MSCP_C_STOP:     op = MSCP_OP_STOP;
            `MSCP_C_START:    op = MSCP_OP_START;
            `MSCP_C_PROG:     op = MSCP_OP_PROG;
            `MSCP_C_EDGE:     op = MSCP_OP_EDGE;
            `MSCP_C_RD_OPT:   op = MSCP_OP_RD_OPT;
            `MSCP_C_RD_PRG:   op = MSCP_OP_RD_PRG;
            `MSCP_C_WR_OPT:   op = MSCP_OP_WR_OPT;
            `MSCP_C_WR_PRG:   op = MSCP_OP_WR_PRG;
            `MSCP_C_SV_OPT:   op = MSCP_OP_SV_OPT;
            `MSCP_C_SV_PRG:   op = MSCP_OP_SV_PRG;
            `MSCP_C_TRG_RST:  op = MSCP_OP_TRG_RST;
            `MSCP_C_TRG_GO:   op = MSCP_OP_TRG_GO;
            `MSCP_C_TH_ADAPT: op = MSCP_OP_TH_ADAPT;
            `MSCP_C_TH_FIXED: op = MSCP_OP_TH_FIXED;
            `MSCP_C_EXT_RD:   op = MSCP_OP_EXT_RD;
            `MSCP_C_EXT_CLR:  op = MSCP_OP_EXT_CLR;
            default:          op = MSCP_OP_NONE;
        endcase
    end
endmodule : mscp_decode

// *** logic/mscp_defs.svh ***
`ifndef MSCP_DEFS_SVH
`define MSCP_DEFS_SVH

`define MSCP_TAG_LOW      2'h0
`define MSCP_TAG_MID      2'h1
`define MSCP_TAG_HIGH     2'h2
`define MSCP_ERR_MIN      16'hFFF0
`define MSCP_CONN_WORD    32'h0D2B2B2B
`define MSCP_ACK_BIT      15
`define MSCP_ERR_BIT      14
`define MSCP_RESP_LEN     16'h0003
`define MSCP_C_RESET      16'h2001
`define MSCP_C_DEVICE_INFORMATION_CMD       16'h2011
`define MSCP_C_STOP       16'h2021
`define MSCP_C_START      16'h2022
`define MSCP_C_PROG       16'h2023
`define MSCP_C_EDGE       16'h2024
`define MSCP_C_RD_OPT     16'h2025
`define MSCP_C_RD_PRG     16'h2026
`define MSCP_C_WR_OPT     16'h2027
`define MSCP_C_WR_PRG     16'h2028
`define MSCP_C_SV_OPT     16'h2029
`define MSCP_C_SV_PRG     16'h202A
`define MSCP_C_TRG_RST    16'h202B
`define MSCP_C_TRG_GO     16'h202C
`define MSCP_C_TH_ADAPT   16'h202D
`define MSCP_C_TH_FIXED   16'h202E
`define MSCP_C_EXT_RD     16'h2033
`define MSCP_C_EXT_CLR    16'h2034
`define MSCP_FIFO_DEPTH   4
`endif

// *** logic/mscp_fifo.sv ***
`timescale 1ns/1ps
module mscp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid && in_ready && ce;
    wire              pop  = out_valid && out_ready && ce;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : mscp_fifo

// *** logic/mscp_pkg.sv ***
package mscp_pkg;
    typedef struct packed {
        logic [15:0] raw_digital_value;
        logic [1:0]  segment;
        logic        error;
        logic [3:0]  error_code;
    } mscp_meas_t;

    typedef struct packed {
        logic [15:0] code;
        logic [15:0] length;
        logic [31:0] param0;
        logic [31:0] param1;
    } mscp_cmd_t;

    typedef enum logic [4:0] {
        MSCP_OP_NONE, MSCP_OP_RESET, MSCP_OP_DEVICE_INFORMATION_CMD, MSCP_OP_STOP, MSCP_OP_START,
        MSCP_OP_PROG, MSCP_OP_EDGE, MSCP_OP_RD_OPT, MSCP_OP_RD_PRG,
        MSCP_OP_WR_OPT, MSCP_OP_WR_PRG, MSCP_OP_SV_OPT, MSCP_OP_SV_PRG,
        MSCP_OP_TRG_RST, MSCP_OP_TRG_GO, MSCP_OP_TH_ADAPT, MSCP_OP_TH_FIXED,
        MSCP_OP_EXT_RD, MSCP_OP_EXT_CLR
    } mscp_op_t;
endpackage : mscp_pkg

// *** logic/mscp_port.sv ***
`timescale 1ns/1ps
`include "mscp_defs.svh"
module mscp_port (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // measurement source
    input  mscp_pkg::mscp_meas_t      meas,
    input  wire logic                 meas_valid,
    output logic                      meas_ready,
    // received characters
    input  wire logic [7:0]           rx_data,
    input  wire logic                 rx_valid,
    // transmitted characters
    output logic [7:0]                tx_data,
    output logic                      tx_valid,
    input  wire logic                 tx_ready,
    // command execution
    output mscp_pkg::mscp_cmd_t       cmd,
    output mscp_pkg::mscp_op_t        cmd_op,
    output logic                      cmd_strobe,
    input  wire logic                 cmd_done,
    input  wire logic                 cmd_fail,
    // status
    output logic                      output_enabled,
    output logic                      threshold_adaptive,
    output logic                      reset_request
);
    import mscp_pkg::*;

    typedef enum logic [2:0] {
        RX_HUNT, RX_ID, RX_CMD, RX_PAR, RX_EXEC, RX_RESP
    } mscp_rx_t;

    // receive side
    mscp_rx_t    rx_st_q;
    logic [31:0] shift_q;
    logic [1:0]  bcnt_q;
    logic [15:0] left_q;
    logic [1:0]  pidx_q;
    mscp_cmd_t   cmd_q;
    logic        strobe_q;
    logic        run_q;
    logic        adapt_q;
    logic        rstreq_q;
    // response shift: word count and byte count
    logic [31:0] resp_q;
    logic [1:0]  rword_q;
    logic [1:0]  rbyte_q;
    // measurement serialiser
    mscp_meas_t  cur_q;
    logic [1:0]  mchar_q;
    logic        mbusy_q;
    // fifo
    logic [7:0]  f_in;
    logic        f_in_valid;
    logic        f_in_ready;
    logic [7:0]  f_out;
    logic        f_out_valid;
    logic        tx_valid_q;
    logic [7:0]  tx_data_q;

    mscp_op_t    op_w;
    mscp_op_t    op_q;

    // little-endian assembly
    wire [31:0] word_w   = {rx_data, shift_q[31:8]};
    wire        word_end = rx_valid && (bcnt_q == 2'h3);
    wire        hdr_ok   = word_end && (word_w == `MSCP_CONN_WORD);
    wire [15:0] len_w    = word_w[31:16];

    // decoded as the command word arrives, registered beside cmd_q
    mscp_decode u_dec (
        .code (word_w[15:0]),
        .op   (op_w)
    );

    // value or error code onto the wire
    wire [15:0] dv_w  = cur_q.error ? (`MSCP_ERR_MIN | 16'(cur_q.error_code))
                                    : cur_q.raw_digital_value;
    wire [15:0] dvc_w = (!cur_q.error && cur_q.raw_digital_value >= `MSCP_ERR_MIN)
                      ? (`MSCP_ERR_MIN - 16'h0001) : dv_w;
    wire [7:0]  ch_w  = (mchar_q == 2'h0) ? {`MSCP_TAG_LOW, dvc_w[5:0]} :
                        (mchar_q == 2'h1) ? {`MSCP_TAG_MID, dvc_w[11:6]} :
                        {`MSCP_TAG_HIGH, cur_q.segment, dvc_w[15:12]};

    // response: echoed command, flags, then error word
    wire        fail_w = (op_q == MSCP_OP_NONE) || cmd_fail;
    wire [31:0] echo_w = {`MSCP_RESP_LEN, cmd_q.code | (16'h0001 << `MSCP_ACK_BIT)
                          | (fail_w ? (16'h0001 << `MSCP_ERR_BIT) : 16'h0000)};
    // a started measurement keeps its three characters together
    wire        resp_st   = (rx_st_q == RX_RESP);
    wire        resp_on   = resp_st && !mbusy_q;
    wire [7:0]  resp_ch   = resp_q[7:0];
    wire        meas_on   = mbusy_q;
    assign f_in       = resp_on ? resp_ch : ch_w;
    assign f_in_valid = resp_on || meas_on;
    wire        f_take = f_in_valid && f_in_ready && ce;

    mscp_fifo #(.WIDTH(8), .DEPTH(`MSCP_FIFO_DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .in_data   (f_in),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .out_data  (f_out),
        .out_valid (f_out_valid),
        .out_ready (!tx_valid_q || tx_ready)
    );

    assign meas_ready = ce && !mbusy_q && !resp_st && run_q;

    // output register stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
        end else if (ce && (!tx_valid_q || tx_ready)) begin
            tx_valid_q <= f_out_valid;
            tx_data_q  <= f_out;
        end
    end

    // measurement serialiser
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_q   <= '0;
            mchar_q <= 2'h0;
            mbusy_q <= 1'b0;
        end else if (ce) begin
            if (meas_valid && meas_ready) begin
                cur_q   <= meas;
                mchar_q <= 2'h0;
                mbusy_q <= 1'b1;
            end else if (meas_on && f_take) begin
                mchar_q <= mchar_q + 2'h1;
                if (mchar_q == 2'h2) mbusy_q <= 1'b0;
            end
        end
    end

    // command receiver
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_st_q  <= RX_HUNT;
            shift_q  <= '0;
            bcnt_q   <= 2'h0;
            left_q   <= '0;
            pidx_q   <= 2'h0;
            cmd_q    <= '0;
            strobe_q <= 1'b0;
            op_q     <= MSCP_OP_NONE;
            run_q    <= 1'b1;
            adapt_q  <= 1'b0;
            rstreq_q <= 1'b0;
            resp_q   <= '0;
            rword_q  <= 2'h0;
            rbyte_q  <= 2'h0;
        end else if (ce) begin
            strobe_q <= 1'b0;
            rstreq_q <= 1'b0;
            if (rx_valid && rx_st_q != RX_EXEC && rx_st_q != RX_RESP) begin
                shift_q <= word_w;
                bcnt_q  <= (rx_st_q == RX_HUNT && !hdr_ok) ? bcnt_q : bcnt_q + 2'h1;
            end
            case (rx_st_q)
                RX_HUNT: begin
                    // sliding match on the byte stream
                    if (rx_valid) begin
                        bcnt_q <= 2'h3;
                        if (hdr_ok || {rx_data, shift_q[31:8]} == `MSCP_CONN_WORD) begin
                            bcnt_q  <= 2'h0;
                            rx_st_q <= RX_ID;
                        end
                    end
                end
                RX_ID: begin
                    if (word_end) rx_st_q <= RX_CMD;
                end
                RX_CMD: begin
                    if (word_end) begin
                        cmd_q.code   <= word_w[15:0];
                        op_q         <= op_w;
                        cmd_q.length <= len_w;
                        cmd_q.param0 <= '0;
                        cmd_q.param1 <= '0;
                        left_q       <= len_w;
                        pidx_q       <= 2'h0;
                        rx_st_q      <= (len_w == 16'h0000) ? RX_EXEC : RX_PAR;
                        strobe_q     <= (len_w == 16'h0000);
                    end
                end
                RX_PAR: begin
                    if (word_end) begin
                        if (pidx_q == 2'h0) cmd_q.param0 <= word_w;
                        if (pidx_q == 2'h1) cmd_q.param1 <= word_w;
                        if (pidx_q != 2'h3) pidx_q <= pidx_q + 2'h1;
                        left_q <= left_q - 16'h0001;
                        if (left_q == 16'h0001) begin
                            rx_st_q  <= RX_EXEC;
                            strobe_q <= 1'b1;
                        end
                    end
                end
                RX_EXEC: begin
                    if (op_q == MSCP_OP_NONE || cmd_done) begin
                        if (op_q == MSCP_OP_START) run_q <= 1'b1;
                        if (op_q == MSCP_OP_STOP) run_q <= 1'b0;
                        if (op_q == MSCP_OP_RESET) run_q <= 1'b1;
                        if (op_q == MSCP_OP_RESET) rstreq_q <= 1'b1;
                        if (op_q == MSCP_OP_TH_ADAPT) adapt_q <= 1'b1;
                        if (op_q == MSCP_OP_TH_FIXED) adapt_q <= 1'b0;
                        resp_q  <= echo_w;
                        rword_q <= 2'h0;
                        rbyte_q <= 2'h0;
                        rx_st_q <= RX_RESP;
                    end
                end
                RX_RESP: begin
                    if (resp_on && f_take) begin
                        resp_q  <= {8'h00, resp_q[31:8]};
                        rbyte_q <= rbyte_q + 2'h1;
                        if (rbyte_q == 2'h3) begin
                            // echo word, then an all-zero error word
                            rword_q <= rword_q + 2'h1;
                            resp_q  <= 32'h00000000;
                            if (rword_q == 2'h1) begin
                                rx_st_q <= RX_HUNT;
                                bcnt_q  <= 2'h0;
                            end
                        end
                    end
                end
                default: rx_st_q <= RX_HUNT;
            endcase
        end
    end

    assign tx_data            = tx_data_q;
    assign tx_valid           = tx_valid_q;
    assign cmd                = cmd_q;
    assign cmd_op             = op_q;
    assign cmd_strobe         = strobe_q;
    assign output_enabled     = run_q;
    assign threshold_adaptive = adapt_q;
    assign reset_request      = rstreq_q;
endmodule : mscp_port
